// File: logic/smb_pkg.sv
// What this block does
// - after a received master byte, report status 1000, ack_requested 1, arbitration_lost 0.
// - start clear, stop set, ack 0: send NACK then STOP, transfer ends.
// - start and stop set, ack 0: NACK, STOP, then new START; status 1110 follows.
// - start set, stop clear, ack 1: ACK the byte, then repeated START, status 1110.
// - start set, stop clear, ack 0: NACK the byte, then repeated START, status 1110.
// - data written before event clear, ack 1, no start/stop: ACK, transmit, status 1100.
// - data written before event clear, ack 0, no start/stop: NACK, transmit, status 1100.
// - configuration register, 8 bits at 0xC1, resets to zero, fields at fixed bit positions.
// - the bus interface runs only while interface_enable_bit is 1.
// - slave_inhibit set: slave events raise no event flag.
// - slave_inhibit leaves master-mode events untouched.
// - busy sets while a transfer runs, clears on STOP or bus-free timeout.
package smb_pkg;

   localparam logic [7:0] CFG_ADDR = 8'hC1;
   localparam logic [7:0] CTRL_ADDR = 8'hC0;
   localparam logic [7:0] DATA_ADDR = 8'hC2;

   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'hDF;
   localparam logic [7:0] DATA_RESET = 8'h00;

   localparam int unsigned CFG_EN = 7;
   localparam int unsigned CFG_INH = 6;
   localparam int unsigned CFG_BUSY = 5;
   localparam int unsigned CFG_FTE = 2;

   localparam int unsigned CTL_MASTER = 7;
   localparam int unsigned CTL_TXMODE = 6;
   localparam int unsigned CTL_STA = 5;
   localparam int unsigned CTL_STO = 4;
   localparam int unsigned CTL_ACK_REQUESTED = 3;
   localparam int unsigned CTL_ARB = 2;
   localparam int unsigned CTL_ACK = 1;
   localparam int unsigned CTL_EVENT = 0;

   localparam logic [3:0] TX_BITS = 4'h9;
   localparam logic [3:0] RX_BITS = 4'h8;
   localparam logic [3:0] ACK_BITS = 4'h1;

   // bus-free timeout, in link clock periods
   localparam logic [3:0] FREE_PERIODS = 4'hA;

   typedef enum logic [4:0] {
      RES_START = 5'h01,
      RES_TX = 5'h02,
      RES_RX = 5'h04,
      RES_ARB = 5'h08,
      RES_STOP = 5'h10
   } smb_res_t;

   typedef enum logic [5:0] {
      LS_IDLE = 6'h01,
      LS_WAIT = 6'h02,
      LS_NEXT = 6'h04,
      LS_START = 6'h08,
      LS_XFER = 6'h10,
      LS_STOP = 6'h20
   } smb_lstate_t;

   typedef enum logic [2:0] {
      XK_TX = 3'h1,
      XK_RX = 3'h2,
      XK_ACK = 3'h4
   } smb_xkind_t;

endpackage

// File: logic/smb_sync.sv
module smb_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta;

   // meta feeds only the second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// File: logic/smb_master_rx.sv
module smb_master_rx
   import smb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);

   // ---------------- system clock side ----------------
   logic [7:0] cfg_q;
   logic master;
   logic txmode;
   logic start_request;
   logic stop_request;
   logic ack_requested;
   logic arb;
   logic ack;
   logic evt;
   logic [7:0] data_q;
   logic data_written;
   logic cmd_tgl;
   logic cmd_out;
   logic c_ack_first;
   logic c_sto;
   logic c_sta;
   logic c_tx;
   logic c_ack;
   logic [7:0] c_byte;
   logic done_seen;
   logic slave_seen;
   logic [2:0] back_s;
   logic done_ev;
   logic slave_ev;
   logic busy_s;
   logic wr_cfg;
   logic wr_ctrl;
   logic wr_data;
   logic clear_evt;
   logic issue;
   logic [7:0] next_rdata;

   // ---------------- link clock side ----------------
   smb_lstate_t lstate;
   smb_xkind_t xkind;
   smb_res_t res;
   logic [1:0] ph;
   logic [3:0] cnt;
   logic [8:0] sh;
   logic p_ack;
   logic p_sto;
   logic p_sta;
   logic p_tx;
   logic [7:0] rx_byte;
   logic rx_ackbit;
   logic done_tgl;
   logic cmd_seen;
   logic slave_tgl;
   logic busy;
   logic prev_scl;
   logic prev_sda;
   logic [3:0] free_cnt;
   logic [1:0] pins_s;
   logic [2:0] ctl_s;
   logic scl_s;
   logic sda_s;
   logic cmd_l;
   logic en_l;
   logic fte_l;
   logic cmd_new;
   logic start_det;
   logic stop_det;

   // ---------------- crossings ----------------
   smb_sync #(.WIDTH(3)) u_back_sync (
      .clk(sys_clk),
      .reset_n(reset_n),
      .din({done_tgl, slave_tgl, busy}),
      .dout(back_s)
   );

   smb_sync #(.WIDTH(3)) u_ctl_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .din({cmd_tgl, cfg_q[CFG_EN], cfg_q[CFG_FTE]}),
      .dout(ctl_s)
   );

   smb_sync #(.WIDTH(2)) u_pin_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .din({scl_in, sda_in}),
      .dout(pins_s)
   );

   assign busy_s = back_s[0];
   assign done_ev = back_s[2] ^ done_seen;
   assign slave_ev = back_s[1] ^ slave_seen;
   assign cmd_l = ctl_s[2];
   assign en_l = ctl_s[1];
   assign fte_l = ctl_s[0];
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // ---------------- register access ----------------
   assign wr_cfg = sfr_wr && (sfr_addr == CFG_ADDR);
   assign wr_ctrl = sfr_wr && (sfr_addr == CTRL_ADDR);
   assign wr_data = sfr_wr && (sfr_addr == DATA_ADDR);
   assign clear_evt = wr_ctrl && evt && !sfr_wdata[CTL_EVENT];
   // the event clear is what releases the selected response
   assign issue = cfg_q[CFG_EN] && !cmd_out && wr_ctrl &&
      ((clear_evt && master) || (!master && !evt && sfr_wdata[CTL_STA]));

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= sfr_wdata & CFG_WMASK;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (sfr_addr == CFG_ADDR) begin
         next_rdata = cfg_q;
         next_rdata[CFG_BUSY] = busy_s;
      end else if (sfr_addr == CTRL_ADDR) begin
         next_rdata = {master, txmode, start_request, stop_request, ack_requested, arb, ack, evt};
      end else if (sfr_addr == DATA_ADDR) begin
         next_rdata = data_q;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= next_rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_seen <= 1'b0;
         slave_seen <= 1'b0;
      end else begin
         done_seen <= back_s[2];
         slave_seen <= back_s[1];
      end
   end

   // command words stay frozen while outstanding, so the link side may sample them late
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_tgl <= 1'b0;
         cmd_out <= 1'b0;
         c_ack_first <= 1'b0;
         c_sto <= 1'b0;
         c_sta <= 1'b0;
         c_tx <= 1'b0;
         c_ack <= 1'b0;
         c_byte <= DATA_RESET;
      end else if (issue) begin
         cmd_tgl <= ~cmd_tgl;
         cmd_out <= 1'b1;
         c_ack_first <= ack_requested;
         c_sto <= sfr_wdata[CTL_STO];
         c_sta <= sfr_wdata[CTL_STA];
         c_ack <= sfr_wdata[CTL_ACK];
         c_tx <= data_written;
         c_byte <= data_q;
      end else if (done_ev || !cfg_q[CFG_EN]) begin
         cmd_out <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_q <= DATA_RESET;
         data_written <= 1'b0;
      end else begin
         if (wr_data) begin
            data_q <= sfr_wdata;
         end else if (done_ev && res == RES_RX) begin
            data_q <= rx_byte;
         end
         if (wr_data) begin
            data_written <= 1'b1;
         end else if (issue) begin
            data_written <= 1'b0;
         end
      end
   end

   // hardware updates come last so an event never loses to a software write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_request <= 1'b0;
         stop_request <= 1'b0;
         ack <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            start_request <= sfr_wdata[CTL_STA];
            stop_request <= sfr_wdata[CTL_STO];
            ack <= sfr_wdata[CTL_ACK];
         end
         if (done_ev) begin
            unique case (res)
               RES_START: stop_request <= 1'b0;
               RES_TX: ack <= rx_ackbit;
               RES_RX: ack <= ack;
               RES_ARB: start_request <= 1'b0;
               RES_STOP: begin
                  start_request <= 1'b0;
                  stop_request <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         master <= 1'b0;
         txmode <= 1'b0;
      end else if (!cfg_q[CFG_EN]) begin
         master <= 1'b0;
         txmode <= 1'b0;
      end else if (done_ev) begin
         unique case (res)
            RES_START: begin
               master <= 1'b1;
               txmode <= 1'b1;
            end
            RES_TX: txmode <= 1'b1;
            RES_RX: txmode <= 1'b0;
            RES_ARB: begin
               master <= 1'b0;
               txmode <= 1'b0;
            end
            RES_STOP: begin
               master <= 1'b0;
               txmode <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_requested <= 1'b0;
      end else if (done_ev && res == RES_RX) begin
         ack_requested <= 1'b1;
      end else if (issue || !cfg_q[CFG_EN]) begin
         ack_requested <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         arb <= 1'b0;
      end else if (done_ev && res == RES_ARB) begin
         arb <= 1'b1;
      end else if (clear_evt || (done_ev && res == RES_RX)) begin
         arb <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         evt <= 1'b0;
      end else if (done_ev && res != RES_STOP) begin
         evt <= 1'b1;
      end else if (slave_ev && !cfg_q[CFG_INH] && cfg_q[CFG_EN]) begin
         evt <= 1'b1;
      end else if (clear_evt) begin
         evt <= 1'b0;
      end
   end

   // ---------------- link side: bus monitor ----------------
   assign cmd_new = cmd_l ^ cmd_seen;
   assign start_det = prev_scl && scl_s && prev_sda && !sda_s;
   assign stop_det = prev_scl && scl_s && !prev_sda && sda_s;

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_scl <= 1'b0;
         prev_sda <= 1'b0;
         free_cnt <= 4'h0;
      end else begin
         prev_scl <= scl_s;
         prev_sda <= sda_s;
         if (!(scl_s && sda_s)) begin
            free_cnt <= 4'h0;
         end else if (free_cnt != FREE_PERIODS) begin
            free_cnt <= free_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         slave_tgl <= 1'b0;
      end else if (!en_l) begin
         busy <= 1'b0;
      end else begin
         if (start_det) begin
            busy <= 1'b1;
         end else if (stop_det || (fte_l && free_cnt == FREE_PERIODS)) begin
            busy <= 1'b0;
         end
         // a START we did not make while idle is a slave-side event
         if (start_det && lstate == LS_IDLE) begin
            slave_tgl <= ~slave_tgl;
         end
      end
   end

   // ---------------- link side: master engine ----------------
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         lstate <= LS_IDLE;
         xkind <= XK_RX;
         res <= RES_STOP;
         ph <= 2'h0;
         cnt <= 4'h0;
         sh <= 9'h1FF;
         p_ack <= 1'b0;
         p_sto <= 1'b0;
         p_sta <= 1'b0;
         p_tx <= 1'b0;
         rx_byte <= 8'h00;
         rx_ackbit <= 1'b0;
         done_tgl <= 1'b0;
         cmd_seen <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else if (!en_l) begin
         lstate <= LS_IDLE;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         cmd_seen <= cmd_l;
         p_ack <= 1'b0;
         p_sto <= 1'b0;
         p_sta <= 1'b0;
         p_tx <= 1'b0;
      end else begin
         unique case (lstate)
            LS_IDLE, LS_WAIT: begin
               if (lstate == LS_IDLE) begin
                  scl_oe_n <= 1'b1;
                  sda_oe_n <= 1'b1;
               end
               if (cmd_new) begin
                  cmd_seen <= cmd_l;
                  p_ack <= c_ack_first;
                  p_sto <= c_sto;
                  p_sta <= c_sta;
                  p_tx <= c_tx;
                  lstate <= LS_NEXT;
               end
            end
            LS_NEXT: begin
               ph <= 2'h0;
               if (p_ack) begin
                  // ack bit 1 pulls SDA low, 0 leaves it high as a NACK
                  sh <= {!c_ack, 8'hFF};
                  cnt <= ACK_BITS;
                  xkind <= XK_ACK;
                  p_ack <= 1'b0;
                  lstate <= LS_XFER;
               end else if (p_sto) begin
                  p_sto <= 1'b0;
                  lstate <= LS_STOP;
               end else if (p_sta) begin
                  p_sta <= 1'b0;
                  lstate <= LS_START;
               end else if (p_tx) begin
                  sh <= {c_byte, 1'b1};
                  cnt <= TX_BITS;
                  xkind <= XK_TX;
                  p_tx <= 1'b0;
                  lstate <= LS_XFER;
               end else begin
                  sh <= 9'h1FF;
                  cnt <= RX_BITS;
                  xkind <= XK_RX;
                  lstate <= LS_XFER;
               end
            end
            LS_START: begin
               unique case (ph)
                  2'h0: begin
                     sda_oe_n <= 1'b1;
                     ph <= 2'h1;
                  end
                  2'h1: begin
                     scl_oe_n <= 1'b1;
                     ph <= 2'h2;
                  end
                  2'h2: begin
                     // waits out clock stretching before the falling SDA edge
                     if (scl_s && sda_s) begin
                        sda_oe_n <= 1'b0;
                        ph <= 2'h3;
                     end
                  end
                  2'h3: begin
                     scl_oe_n <= 1'b0;
                     res <= RES_START;
                     done_tgl <= ~done_tgl;
                     ph <= 2'h0;
                     lstate <= LS_WAIT;
                  end
               endcase
            end
            LS_STOP: begin
               unique case (ph)
                  2'h0: begin
                     sda_oe_n <= 1'b0;
                     ph <= 2'h1;
                  end
                  2'h1: begin
                     scl_oe_n <= 1'b1;
                     ph <= 2'h2;
                  end
                  2'h2: begin
                     if (scl_s) begin
                        sda_oe_n <= 1'b1;
                        ph <= 2'h3;
                     end
                  end
                  2'h3: begin
                     ph <= 2'h0;
                     if (p_sta) begin
                        lstate <= LS_NEXT;
                     end else begin
                        res <= RES_STOP;
                        done_tgl <= ~done_tgl;
                        lstate <= LS_IDLE;
                     end
                  end
               endcase
            end
            LS_XFER: begin
               unique case (ph)
                  2'h0: begin
                     sda_oe_n <= sh[8];
                     ph <= 2'h1;
                  end
                  2'h1: begin
                     scl_oe_n <= 1'b1;
                     ph <= 2'h2;
                  end
                  2'h2: begin
                     if (scl_s) begin
                        sh <= {sh[7:0], sda_s};
                        if (xkind == XK_TX && cnt != ACK_BITS && sh[8] && !sda_s) begin
                           // another master won: let go of both lines at once
                           scl_oe_n <= 1'b1;
                           sda_oe_n <= 1'b1;
                           res <= RES_ARB;
                           done_tgl <= ~done_tgl;
                           ph <= 2'h0;
                           lstate <= LS_IDLE;
                        end else begin
                           ph <= 2'h3;
                        end
                     end
                  end
                  2'h3: begin
                     scl_oe_n <= 1'b0;
                     cnt <= cnt - 4'h1;
                     ph <= 2'h0;
                     if (cnt == ACK_BITS) begin
                        unique case (xkind)
                           XK_TX: begin
                              rx_ackbit <= !sh[0];
                              res <= RES_TX;
                              done_tgl <= ~done_tgl;
                              lstate <= LS_WAIT;
                           end
                           XK_RX: begin
                              // SCL stays low until software decides the ack
                              rx_byte <= sh[7:0];
                              res <= RES_RX;
                              done_tgl <= ~done_tgl;
                              lstate <= LS_WAIT;
                           end
                           XK_ACK: lstate <= LS_NEXT;
                        endcase
                     end
                  end
               endcase
            end
         endcase
      end
   end

endmodule

// File: tb/smb_assertions.sv
module smb_assertions
   import smb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n
);
   logic en_q;
   logic [7:0] dis_cnt;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) en_q <= 1'b0;
      else if (sfr_wr && sfr_addr == CFG_ADDR) en_q <= sfr_wdata[CFG_EN];
   end
   // saturates at 255 so the enable has surely crossed to the link side
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) dis_cnt <= 8'h00;
      else if (en_q) dis_cnt <= 8'h00;
      else if (dis_cnt != 8'hFF) dis_cnt <= dis_cnt + 8'h01;
   end
   sequence cfg_rd_s;
      sfr_addr == CFG_ADDR && !sfr_wr;
   endsequence
   sequence ctl_rd_s;
      sfr_addr == CTRL_ADDR && !sfr_wr;
   endsequence
   property cfg_wr_p;
      logic [7:0] v;
      @(posedge sys_clk) disable iff (!reset_n)
      (sfr_wr && sfr_addr == CFG_ADDR, v = sfr_wdata) ##1 cfg_rd_s
      |=> (sfr_rdata & CFG_WMASK) == (v & CFG_WMASK);
   endproperty
   a_reset_reads_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> sfr_rdata == 8'h00) else $error("read not zero after reset");
   a_cfg_stores_write: assert property (cfg_wr_p) else $error("config readback wrong");
   a_unmapped_reads_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (sfr_addr != CTRL_ADDR && sfr_addr != CFG_ADDR && sfr_addr != DATA_ADDR)
      |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   a_status_ack_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ctl_rd_s ##1 (sfr_rdata[7:4] == 4'h8 && sfr_rdata[CTL_EVENT])
      |-> sfr_rdata[CTL_ACK_REQUESTED] && !sfr_rdata[CTL_ARB]) else $error("receive flags wrong");
   a_event_held: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ctl_rd_s ##1 (ctl_rd_s and sfr_rdata[CTL_EVENT]) |=> sfr_rdata[CTL_EVENT])
      else $error("event flag dropped by itself");
   a_off_lines_free: assert property (@(posedge sys_clk) disable iff (!reset_n)
      dis_cnt == 8'hFF |-> scl_oe_n && sda_oe_n) else $error("disabled but driving");
   a_off_busy_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (dis_cnt == 8'hFF) ##0 cfg_rd_s |=> !sfr_rdata[CFG_BUSY]) else $error("busy while off");
   a_pins_only_low: assert property (@(posedge link_clk) disable iff (!reset_n)
      !scl_out && !sda_out) else $error("line driven high");
endmodule
bind smb_master_rx smb_assertions u_chk (.sys_clk, .reset_n, .link_clk, .sfr_addr, .sfr_wr,
   .sfr_wdata, .sfr_rdata, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n);

// File: tb/smb_slave_model.sv
module smb_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic stretch,
   input wire logic [7:0] tx_byte,
   output logic scl_pull,
   output logic sda_pull,
   output logic ack_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act, rd, addr_ph;
   logic [7:0] sh;
   int bits;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      ack_seen = 1'b0;
      act = 1'b0;
      rd = 1'b0;
   end
   always @(negedge sda) begin
      if (scl) begin
         act = 1'b1;
         addr_ph = 1'b1;
         rd = 1'b0;
         bits = 0;
      end
   end
   always @(posedge sda) begin
      if (scl) act = 1'b0;
   end
   always @(posedge scl) begin
      if (act && bits < 8) sh = {sh[6:0], sda};
      if (act && bits == 8 && rd) ack_seen = !sda;
      if (act) bits = (bits == 8) ? 0 : bits + 1;
   end
   // released lines float to the pull-up, never the last value
   always @(negedge scl) begin
      if (act && bits == 8) begin
         rd = addr_ph ? sh[0] : rd;
         sda_pull = addr_ph || !rd;
         addr_ph = 1'b0;
      end else if (act && rd && ack_seen) begin
         sda_pull = !tx_byte[7 - bits];
      end else begin
         sda_pull = 1'b0;
         act = act && !rd;
      end
      if (act && stretch) begin
         scl_pull = 1'b1;
         #400 scl_pull = 1'b0;
      end
   end
endmodule

// File: tb/smbus_master_receive_and_config_tb_top.sv
module smbus_master_receive_and_config_tb_top
   import smb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, link_clk, reset_n, sfr_wr, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, tx_byte, r;
   logic stretch, ext_sda, scl_pull, sda_pull, ack_seen;
   logic [7:0] vars [3] = '{8'h22, 8'h20, 8'h30};
   wire scl, sda;
   int miscompares, checks, cycles;
   assign scl = scl_oe_n && !scl_pull;
   assign sda = sda_oe_n && !sda_pull && !ext_sda;
   smb_master_rx DUT (.sys_clk, .reset_n, .link_clk, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
      .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out, .sda_oe_n);
   smb_slave_model peer (.scl, .sda, .stretch, .tx_byte, .scl_pull, .sda_pull, .ack_seen);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 100000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wr <= 1'b1;
      sfr_wdata <= d;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      sfr_addr <= a;
      @(posedge sys_clk);
      @(posedge sys_clk);
      #1 r = sfr_rdata;
   endtask
   // bounded poll: a step that never completes shows as a missing event
   task automatic step(input logic [7:0] ctl, input logic [3:0] st);
      int i;
      wr(CTRL_ADDR, ctl);
      i = 0;
      r = 8'h00;
      while (!r[CTL_EVENT] && i < 4000) begin
         rd(CTRL_ADDR);
         i++;
      end
      chk({r[7:4], 3'h0, r[CTL_EVENT]}, {st, 4'h1});
   endtask
   task automatic to_rx();
      wr(DATA_ADDR, 8'hA1);
      step(8'h00, 4'hC);
      step(8'h00, 4'h8);
   endtask
   task automatic ext(input logic lvl);
      @(posedge sys_clk);
      ext_sda <= lvl;
      repeat (1000) @(posedge sys_clk);
   endtask
   initial begin
      reset_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      stretch = 1'b0;
      ext_sda = 1'b0;
      tx_byte = 8'hA5;
      repeat (16) @(posedge link_clk);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(CFG_ADDR);
      chk(r, CFG_RESET);
      rd(8'hC3);
      chk(r, 8'h00);
      wr(CFG_ADDR, 8'h20);
      wr(CTRL_ADDR, 8'h20);
      repeat (2000) @(posedge sys_clk);
      rd(CFG_ADDR);
      chk(r, 8'h00);
      rd(CTRL_ADDR);
      chk({6'h00, r[CTL_MASTER], r[CTL_EVENT]}, 8'h00);
      wr(CTRL_ADDR, 8'h00);
      wr(CFG_ADDR, 8'hFF);
      rd(CFG_ADDR);
      chk(r, 8'hDF);
      ext(1'b1);
      rd(CTRL_ADDR);
      chk({r[7:4], 3'h0, r[CTL_EVENT]}, 8'h00);
      rd(CFG_ADDR);
      chk(r, 8'hFF);
      ext(1'b0);
      rd(CFG_ADDR);
      chk(r, 8'hDF);
      wr(CFG_ADDR, 8'h80);
      ext(1'b1);
      rd(CTRL_ADDR);
      chk({r[7:4], 3'h0, r[CTL_EVENT]}, 8'h01);
      wr(CTRL_ADDR, 8'h00);
      ext(1'b0);
      wr(CFG_ADDR, 8'hC0);
      repeat (200) @(posedge sys_clk);
      step(8'h20, 4'hE);
      to_rx();
      chk(r & 8'hFD, 8'h89);
      rd(DATA_ADDR);
      chk(r, 8'hA5);
      tx_byte <= 8'hFF;
      stretch <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         step(vars[k], 4'hE);
         to_rx();
      end
      wr(DATA_ADDR, 8'h3C);
      step(8'h02, 4'hC);
      step(8'h20, 4'hE);
      to_rx();
      wr(DATA_ADDR, 8'h3C);
      step(8'h00, 4'hC);
      step(8'h20, 4'hE);
      to_rx();
      wr(CTRL_ADDR, 8'h10);
      repeat (3000) @(posedge sys_clk);
      rd(CTRL_ADDR);
      chk({3'h0, scl, sda, r[CTL_MASTER], r[CTL_EVENT], ack_seen}, 8'h18);
      rd(CFG_ADDR);
      chk(r, 8'hC0);
      // a foreign low on SDA while the first address bit is a 1 must cost the bus
      step(8'h20, 4'hE);
      wr(DATA_ADDR, 8'hFF);
      ext(1'b1);
      step(8'h00, 4'h0);
      chk(r & 8'h04, 8'h04);
      ext(1'b0);
      rd(CFG_ADDR);
      chk(r, 8'hC0);
      results();
   end
endmodule
